// ==== fpu_stack_pkg.sv ====
// Shared types and constants for the floating point stack instruction unit
`default_nettype none
package fpu_stack_pkg;
  localparam logic [7:0] ESC_D8 = 8'hD8;
  localparam logic [7:0] ESC_D9 = 8'hD9;
  localparam logic [7:0] ESC_DA = 8'hDA;
  localparam logic [7:0] ESC_DB = 8'hDB;
  localparam logic [7:0] ESC_DC = 8'hDC;
  localparam logic [7:0] ESC_DD = 8'hDD;
  localparam logic [7:0] ESC_DE = 8'hDE;
  localparam logic [7:0] ESC_DF = 8'hDF;
  localparam logic [7:0] WAIT_BYTE = 8'h9B;
  // Second-byte opcodes of the fixed forms
  localparam logic [7:0] B_ATAN = 8'hF3;
  localparam logic [7:0] B_PREM = 8'hF8;
  localparam logic [7:0] B_PREM1 = 8'hF5;
  localparam logic [7:0] B_TAN = 8'hF2;
  localparam logic [7:0] B_SCALE = 8'hFD;
  localparam logic [7:0] B_SIN = 8'hFE;
  localparam logic [7:0] B_SINCOS = 8'hFB;
  localparam logic [7:0] B_SQRT = 8'hFA;
  localparam logic [7:0] B_TST = 8'hE4;
  localparam logic [7:0] B_XAM = 8'hE5;
  localparam logic [7:0] B_XTRACT = 8'hF4;
  localparam logic [7:0] B_YL2X = 8'hF1;
  localparam logic [7:0] B_YL2XP1 = 8'hF9;
  localparam logic [7:0] B_UCOMPP = 8'hE9;
  localparam logic [7:0] B_STSWAX = 8'hE0;
  // Register-form prefixes (upper five bits of the second byte)
  localparam logic [4:0] RF_XCH = 5'h19;
  localparam logic [4:0] RF_STN = 5'h1A;
  localparam logic [4:0] RF_STPN = 5'h1B;
  localparam logic [4:0] RF_E0 = 5'h1C;
  localparam logic [4:0] RF_E1 = 5'h1D;
  localparam logic [1:0] MOD_REG = 2'h3;
  // Execution clocks: lower figure of each printed range
  localparam logic [7:0] CYC_ATAN = 8'd97;
  localparam logic [7:0] CYC_PREM = 8'd82;
  localparam logic [7:0] CYC_TAN = 8'd117;
  localparam logic [7:0] CYC_SCALE = 8'd7;
  localparam logic [7:0] CYC_RSTOR = 8'd56;
  localparam logic [7:0] CYC_SAVE = 8'd55;
  localparam logic [7:0] CYC_WAIT = 8'd2;
  localparam logic [7:0] CYC_SIN = 8'd76;
  localparam logic [7:0] CYC_SINCOS = 8'd145;
  localparam logic [7:0] CYC_SQRT = 8'd59;
  localparam logic [7:0] CYC_STORE = 8'd2;
  localparam logic [7:0] CYC_BCD = 8'd57;
  localparam logic [7:0] CYC_IST32 = 8'd8;
  localparam logic [7:0] CYC_IST16 = 8'd7;
  localparam logic [7:0] CYC_IST64 = 8'd10;
  localparam logic [7:0] CYC_STCW = 8'd3;
  localparam logic [7:0] CYC_STENV = 8'd12;
  localparam logic [7:0] CYC_STSW = 8'd4;
  localparam logic [7:0] CYC_STSWAX = 8'd2;
  localparam logic [7:0] CYC_SUB = 8'd4;
  localparam logic [7:0] CYC_ISUB = 8'd14;
  localparam logic [7:0] CYC_CMP = 8'd4;
  localparam logic [7:0] CYC_XCH = 8'd3;
  localparam logic [7:0] CYC_XTRACT = 8'd11;
  localparam logic [7:0] CYC_YL2X = 8'd145;
  localparam logic [7:0] CYC_YL2XP1 = 8'd131;
  // Extra clocks of the wait-prefixed forms
  localparam logic [7:0] CYC_WAIT_PREFIX = 8'd2;
  localparam logic [2:0] TOP_RESET = 3'h0;

  typedef enum logic [4:0] {
    OP_ILLEGAL = 5'b00000, OP_ATAN = 5'b00001, OP_PREM = 5'b00010,
    OP_PREM1 = 5'b00011, OP_TAN = 5'b00100, OP_SCALE = 5'b00101,
    OP_RSTOR = 5'b00110, OP_SAVE = 5'b00111, OP_WAIT = 5'b01000,
    OP_SIN = 5'b01001, OP_SINCOS = 5'b01010, OP_SQRT = 5'b01011,
    OP_STREG = 5'b01100, OP_STMEM = 5'b01101, OP_BCDST = 5'b01110,
    OP_ISTORE = 5'b01111, OP_STCW = 5'b10000, OP_STENV = 5'b10001,
    OP_STSW = 5'b10010, OP_STSWAX = 5'b10011, OP_SUB = 5'b10100,
    OP_SUBR = 5'b10101, OP_ISUB = 5'b10110, OP_TST = 5'b10111,
    OP_UCOM = 5'b11000, OP_XAM = 5'b11001, OP_XCH = 5'b11010,
    OP_XTRACT = 5'b11011, OP_YL2X = 5'b11100, OP_YL2XP1 = 5'b11101
  } op_t;

  typedef struct packed {
    op_t op;
    logic [7:0] cycles;
    logic [1:0] pops;
    logic push;
    logic useN;
    logic nDst;
    logic mem;
  } dec_t;

  typedef struct packed {
    op_t op;
    logic [2:0] top;
    logic [2:0] src;
    logic [2:0] dst;
    logic [1:0] pops;
    logic push;
    logic mem;
  } res_t;
endpackage
`default_nettype wire

// ==== fpu_stack_instruction_unit.sv ====
// Floating point stack instruction decoder, sequencer and stack pointer
//
// Contract
// - D9 F3: ST1 becomes arctan(ST1/top), then pop; 97-161 clocks.
// - D9 F8 and D9 F5: top becomes remainder of top/ST1; 82-91 clocks.
// - D9 F2: top becomes tangent, then push 1.0; 117-129 clocks.
// - D9 FD: top scaled by two to the ST1 power; 7-14 clocks.
// - DD /4 restores state in 56-72; DD /6 saves without wait in 55-65.
// - Byte 9B stalls until unit idle; alone it takes 2 clocks.
// - D9 FE: top becomes its sine; 76-140 clocks.
// - D9 FB: top becomes sine, then cosine pushed; 145-161 clocks.
// - D9 FA: top becomes square root; 59-60 clocks.
// - Non-popping real store to register n or memory in 2 clocks.
// - Popping real store to register n or memory, then pop, 2 clocks.
// - DF /6: packed decimal store then pop; 57-63 clocks.
// - Integer stores; 64-bit always pops, 10-13; 32-bit 8-13 clocks.
// - Control word store 3 clocks; environment store 12-22 clocks.
// - Status word to memory 4 clocks; DF E0 to accumulator 2 clocks.
// - Subtract forms, popping form pops; 4-9 clocks.
// - Reverse subtract swaps operand order; popping form pops.
// - Integer subtract: 32-bit 14-29, 16-bit 14-27 clocks.
// - Test, unordered compare with pops, classify set codes; 4 clocks.
// - Exchange swaps top and register n in 3 clocks.
// - D9 F4: top becomes exponent, significand pushed; 11-16 clocks.
// - Logarithm forms write ST1 times log2, then pop.
// - Pop increments top pointer; push decrements it.
// - Operand indices resolve against stack before execution.
`default_nettype none
module fpu_stack_instruction_unit (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Issue from the integer unit
  input wire logic issueValid,
  input wire logic [7:0] opByte,
  input wire logic [7:0] modrmByte,
  input wire logic waitPrefix,
  output logic issueReady,
  // Completion
  output logic busy,
  output logic done,
  output fpu_stack_pkg::res_t result,
  output logic [2:0] stackTop
);

  function automatic fpu_stack_pkg::dec_t decode(input logic [7:0] b0,
                                                 input logic [7:0] b1);
    fpu_stack_pkg::dec_t d;
    logic [2:0] r;
    d = '0;
    d.op = fpu_stack_pkg::OP_ILLEGAL;
    d.cycles = fpu_stack_pkg::CYC_WAIT;
    d.mem = (b1[7:6] != fpu_stack_pkg::MOD_REG);
    r = b1[5:3];
    case (b0)
      fpu_stack_pkg::WAIT_BYTE: begin
        d.op = fpu_stack_pkg::OP_WAIT;
        d.mem = 1'b0;
      end
      fpu_stack_pkg::ESC_D9: begin
        if (d.mem) begin
          case (r)
            3'd2, 3'd3: begin
              d.op = fpu_stack_pkg::OP_STMEM;
              d.cycles = fpu_stack_pkg::CYC_STORE;
              d.pops = {1'b0, r[0]};
            end
            3'd6: begin
              d.op = fpu_stack_pkg::OP_STENV;
              d.cycles = fpu_stack_pkg::CYC_STENV;
            end
            3'd7: begin
              d.op = fpu_stack_pkg::OP_STCW;
              d.cycles = fpu_stack_pkg::CYC_STCW;
            end
            default: d.op = fpu_stack_pkg::OP_ILLEGAL;
          endcase
        end else begin
          case (b1)
            fpu_stack_pkg::B_ATAN: begin
              d.op = fpu_stack_pkg::OP_ATAN;
              d.cycles = fpu_stack_pkg::CYC_ATAN;
              d.pops = 2'd1;
              d.nDst = 1'b1;
            end
            fpu_stack_pkg::B_PREM: begin
              d.op = fpu_stack_pkg::OP_PREM;
              d.cycles = fpu_stack_pkg::CYC_PREM;
            end
            fpu_stack_pkg::B_PREM1: begin
              d.op = fpu_stack_pkg::OP_PREM1;
              d.cycles = fpu_stack_pkg::CYC_PREM;
            end
            fpu_stack_pkg::B_TAN: begin
              d.op = fpu_stack_pkg::OP_TAN;
              d.cycles = fpu_stack_pkg::CYC_TAN;
              d.push = 1'b1;
            end
            fpu_stack_pkg::B_SCALE: begin
              d.op = fpu_stack_pkg::OP_SCALE;
              d.cycles = fpu_stack_pkg::CYC_SCALE;
            end
            fpu_stack_pkg::B_SIN: begin
              d.op = fpu_stack_pkg::OP_SIN;
              d.cycles = fpu_stack_pkg::CYC_SIN;
            end
            fpu_stack_pkg::B_SINCOS: begin
              d.op = fpu_stack_pkg::OP_SINCOS;
              d.cycles = fpu_stack_pkg::CYC_SINCOS;
              d.push = 1'b1;
            end
            fpu_stack_pkg::B_SQRT: begin
              d.op = fpu_stack_pkg::OP_SQRT;
              d.cycles = fpu_stack_pkg::CYC_SQRT;
            end
            fpu_stack_pkg::B_TST: begin
              d.op = fpu_stack_pkg::OP_TST;
              d.cycles = fpu_stack_pkg::CYC_CMP;
            end
            fpu_stack_pkg::B_XAM: begin
              d.op = fpu_stack_pkg::OP_XAM;
              d.cycles = fpu_stack_pkg::CYC_CMP;
            end
            fpu_stack_pkg::B_XTRACT: begin
              d.op = fpu_stack_pkg::OP_XTRACT;
              d.cycles = fpu_stack_pkg::CYC_XTRACT;
              d.push = 1'b1;
            end
            fpu_stack_pkg::B_YL2X, fpu_stack_pkg::B_YL2XP1: begin
              d.op = b1[3] ? fpu_stack_pkg::OP_YL2XP1 : fpu_stack_pkg::OP_YL2X;
              d.cycles = b1[3] ? fpu_stack_pkg::CYC_YL2XP1 : fpu_stack_pkg::CYC_YL2X;
              d.pops = 2'd1;
              d.nDst = 1'b1;
            end
            default: begin
              if (b1[7:3] == fpu_stack_pkg::RF_XCH) begin
                d.op = fpu_stack_pkg::OP_XCH;
                d.cycles = fpu_stack_pkg::CYC_XCH;
                d.useN = 1'b1;
              end
            end
          endcase
        end
      end
      fpu_stack_pkg::ESC_DA, fpu_stack_pkg::ESC_DE, fpu_stack_pkg::ESC_D8,
      fpu_stack_pkg::ESC_DC: begin
        if (d.mem) begin
          if (r[2:1] == 2'b10) begin
            d.op = r[0] ? fpu_stack_pkg::OP_SUBR : fpu_stack_pkg::OP_SUB;
            d.cycles = fpu_stack_pkg::CYC_SUB;
            if (b0[1]) begin
              d.op = fpu_stack_pkg::OP_ISUB;
              d.cycles = fpu_stack_pkg::CYC_ISUB;
            end
          end
        end else if (b0 == fpu_stack_pkg::ESC_DA) begin
          if (b1 == fpu_stack_pkg::B_UCOMPP) begin
            d.op = fpu_stack_pkg::OP_UCOM;
            d.cycles = fpu_stack_pkg::CYC_CMP;
            d.pops = 2'd2;
          end
        end else if (b1[7:4] == 4'hE) begin
          // register forms
          // D8: bit3 set is reverse into n; DC and DE: bit3 set is forward into n
          d.op = (b1[3] ^ (b0 != fpu_stack_pkg::ESC_D8)) ?
                 fpu_stack_pkg::OP_SUBR : fpu_stack_pkg::OP_SUB;
          d.cycles = fpu_stack_pkg::CYC_SUB;
          d.useN = 1'b1;
          d.nDst = (b0 == fpu_stack_pkg::ESC_D8) ? b1[3] : (b0 == fpu_stack_pkg::ESC_DE) | b1[3];
          d.pops = {1'b0, b0 == fpu_stack_pkg::ESC_DE};
        end
      end
      fpu_stack_pkg::ESC_DB: begin
        if (d.mem) begin
          if (r[2:1] == 2'b01) begin
            d.op = fpu_stack_pkg::OP_ISTORE;
            d.cycles = fpu_stack_pkg::CYC_IST32;
            d.pops = {1'b0, r[0]};
          end else if (r == 3'd7) begin
            d.op = fpu_stack_pkg::OP_STMEM;
            d.cycles = fpu_stack_pkg::CYC_STORE;
            d.pops = 2'd1;
          end
        end else if (b1[7:3] == fpu_stack_pkg::RF_STPN) begin
          d.op = fpu_stack_pkg::OP_STREG;
          d.cycles = fpu_stack_pkg::CYC_STORE;
          d.pops = 2'd1;
          d.useN = 1'b1;
          d.nDst = 1'b1;
        end
      end
      fpu_stack_pkg::ESC_DD: begin
        if (d.mem) begin
          case (r)
            3'd2, 3'd3: begin
              d.op = fpu_stack_pkg::OP_STMEM;
              d.cycles = fpu_stack_pkg::CYC_STORE;
              d.pops = {1'b0, r[0]};
            end
            3'd4: begin
              d.op = fpu_stack_pkg::OP_RSTOR;
              d.cycles = fpu_stack_pkg::CYC_RSTOR;
            end
            3'd6: begin
              d.op = fpu_stack_pkg::OP_SAVE;
              d.cycles = fpu_stack_pkg::CYC_SAVE;
            end
            3'd7: begin
              d.op = fpu_stack_pkg::OP_STSW;
              d.cycles = fpu_stack_pkg::CYC_STSW;
            end
            default: d.op = fpu_stack_pkg::OP_ILLEGAL;
          endcase
        end else if (b1[7:3] == fpu_stack_pkg::RF_STN) begin
          d.op = fpu_stack_pkg::OP_STREG;
          d.cycles = fpu_stack_pkg::CYC_STORE;
          d.useN = 1'b1;
          d.nDst = 1'b1;
        end else if (b1[7:3] == fpu_stack_pkg::RF_E0 || b1[7:3] == fpu_stack_pkg::RF_E1) begin
          d.op = fpu_stack_pkg::OP_UCOM;
          d.cycles = fpu_stack_pkg::CYC_CMP;
          d.useN = 1'b1;
          d.pops = {1'b0, b1[3]};
        end
      end
      fpu_stack_pkg::ESC_DF: begin
        if (d.mem) begin
          case (r)
            3'd2, 3'd3: begin
              d.op = fpu_stack_pkg::OP_ISTORE;
              d.cycles = fpu_stack_pkg::CYC_IST16;
              d.pops = {1'b0, r[0]};
            end
            3'd6: begin
              d.op = fpu_stack_pkg::OP_BCDST;
              d.cycles = fpu_stack_pkg::CYC_BCD;
              d.pops = 2'd1;
            end
            3'd7: begin
              d.op = fpu_stack_pkg::OP_ISTORE;
              d.cycles = fpu_stack_pkg::CYC_IST64;
              d.pops = 2'd1;
            end
            default: d.op = fpu_stack_pkg::OP_ILLEGAL;
          endcase
        end else if (b1 == fpu_stack_pkg::B_STSWAX) begin
          d.op = fpu_stack_pkg::OP_STSWAX;
          d.cycles = fpu_stack_pkg::CYC_STSWAX;
        end
      end
      default: d.op = fpu_stack_pkg::OP_ILLEGAL;
    endcase
    return d;
  endfunction

  fpu_stack_pkg::dec_t issDec;
  fpu_stack_pkg::res_t pend_reg;
  logic [7:0] cnt_reg;
  logic [2:0] nOff;
  logic take;

  assign issDec = decode(opByte, modrmByte);
  assign take = issueValid && issueReady;
  assign nOff = issDec.useN ? modrmByte[2:0] : 3'd1;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
      issueReady <= 1'b1;
      cnt_reg <= 8'h00;
    end else if (take) begin
      busy <= 1'b1;
      issueReady <= 1'b0;
      cnt_reg <= issDec.cycles - 8'd1 + (waitPrefix ? fpu_stack_pkg::CYC_WAIT_PREFIX : 8'h00);
    end else if (busy) begin
      if (cnt_reg == 8'h00) begin
        busy <= 1'b0;
        issueReady <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg - 8'd1;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pend_reg <= '0;
    end else if (take) begin
      pend_reg.op <= issDec.op;
      pend_reg.top <= stackTop;
      pend_reg.src <= issDec.nDst ? stackTop : stackTop + nOff;
      pend_reg.dst <= issDec.nDst ? stackTop + nOff : stackTop;
      pend_reg.pops <= issDec.pops;
      pend_reg.push <= issDec.push;
      pend_reg.mem <= issDec.mem;
    end
  end

  // Completion pulse and result publish together
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      done <= 1'b0;
      result <= '0;
    end else begin
      done <= busy && cnt_reg == 8'h00;
      if (busy && cnt_reg == 8'h00) begin
        result <= pend_reg;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stackTop <= fpu_stack_pkg::TOP_RESET;
    end else if (busy && cnt_reg == 8'h00) begin
      stackTop <= stackTop + {1'b0, pend_reg.pops} - {2'b00, pend_reg.push};
    end
  end

  property p_atan_time;
    @(posedge mclk) disable iff (!arst_n)
      take && !waitPrefix && issDec.op == fpu_stack_pkg::OP_ATAN |-> ##98 done;
  endproperty
  a_atan_time: assert property (p_atan_time) else $error("arctangent time wrong");
  property p_sqrt_time;
    @(posedge mclk) disable iff (!arst_n)
      take && !waitPrefix && issDec.op == fpu_stack_pkg::OP_SQRT |=> !done [*8] ##52 done;
  endproperty
  a_sqrt_time: assert property (p_sqrt_time) else $error("square root time wrong");
  property p_wait_time;
    @(posedge mclk) disable iff (!arst_n)
      take && !waitPrefix && issDec.op == fpu_stack_pkg::OP_WAIT |=> busy ##2 done;
  endproperty
  a_wait_time: assert property (p_wait_time) else $error("wait time wrong");
  property p_stcw_wait;
    @(posedge mclk) disable iff (!arst_n)
      take && waitPrefix && issDec.op == fpu_stack_pkg::OP_STCW |-> ##6 done;
  endproperty
  a_stcw_wait: assert property (p_stcw_wait) else $error("waiting store time wrong");
  property p_xch_index;
    @(posedge mclk) disable iff (!arst_n)
      take && !waitPrefix && issDec.op == fpu_stack_pkg::OP_XCH |-> ##4
        done && result.dst == $past(stackTop, 4) && result.src == $past(3'(stackTop + nOff), 4);
  endproperty
  a_xch_index: assert property (p_xch_index) else $error("exchange operands wrong");
  property p_pop_ptr;
    @(posedge mclk) disable iff (!arst_n)
      done |-> stackTop == 3'($past(stackTop) + result.pops - result.push);
  endproperty
  a_pop_ptr: assert property (p_pop_ptr) else $error("stack pointer wrong");
  property p_ucompp_pops;
    @(posedge mclk) disable iff (!arst_n)
      take && !waitPrefix && opByte == fpu_stack_pkg::ESC_DA && modrmByte ==
        fpu_stack_pkg::B_UCOMPP |-> ##5 done && result.pops == 2'd2;
  endproperty
  a_ucompp_pops: assert property (p_ucompp_pops) else $error("double pop wrong");
  property p_stswax;
    @(posedge mclk) disable iff (!arst_n)
      take && !waitPrefix && issDec.op == fpu_stack_pkg::OP_STSWAX |-> ##3 done;
  endproperty
  a_stswax: assert property (p_stswax) else $error("status to accumulator time");
  property p_no_issue_busy;
    @(posedge mclk) disable iff (!arst_n) busy |-> !issueReady;
  endproperty
  a_no_issue_busy: assert property (p_no_issue_busy) else $error("ready while busy");
  c_atan: cover property (@(posedge mclk) done && result.op == fpu_stack_pkg::OP_ATAN);
  c_push: cover property (@(posedge mclk) done && result.push);
  c_wait: cover property (@(posedge mclk) take && waitPrefix);
  c_illegal: cover property (@(posedge mclk) done && result.op == fpu_stack_pkg::OP_ILLEGAL);
endmodule // fpu_stack_instruction_unit
`default_nettype wire

// ==== issue_unit_model.sv ====
// Integer-side issuer model that offers floating point instructions to the unit
`default_nettype none
module issue_unit_model (
  // Clock
  input wire logic mclk,
  // Issue handshake
  input wire logic issueReady,
  output logic issueValid,
  output logic [7:0] opByte,
  output logic [7:0] modrmByte,
  output logic waitPrefix
);
  timeunit 1ns;
  timeprecision 1ps;
  int edges = 0;
  initial begin
    issueValid = 1'b0;
    opByte = 8'h00;
    modrmByte = 8'h00;
    waitPrefix = 1'b0;
  end
  always @(posedge mclk) begin
    edges <= edges + 1;
  end
  // Offer on a falling edge, hold until a rising edge samples issueReady high
  task automatic send(input logic [7:0] op, input logic [7:0] mrm, input logic wt,
                      output int takeEdge, output logic ok);
    int n;
    ok = 1'b0;
    @(negedge mclk);
    issueValid = 1'b1;
    opByte = op;
    modrmByte = mrm;
    waitPrefix = wt;
    for (n = 0; n < 400 && !ok; n++) begin
      @(posedge mclk);
      ok = (issueReady === 1'b1);
    end
    // Released bytes show the inverse so a stale value never looks current
    @(negedge mclk);
    takeEdge = edges;
    issueValid = 1'b0;
    opByte = ~op;
    modrmByte = ~mrm;
    waitPrefix = ~wt;
  endtask
endmodule // issue_unit_model
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the floating point stack instruction unit
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic issueValid, waitPrefix, issueReady, busy, done;
  logic [7:0] opByte, modrmByte;
  logic [2:0] stackTop;
  logic [2:0] topModel = 3'h0;
  fpu_stack_pkg::res_t result;
  int badCount = 0;
  int nCompared = 0;

  always #2 mclk = ~mclk;

  fpu_stack_instruction_unit DUT (.mclk(mclk), .arst_n(arst_n), .issueValid(issueValid),
    .opByte(opByte), .modrmByte(modrmByte), .waitPrefix(waitPrefix),
    .issueReady(issueReady), .busy(busy), .done(done), .result(result), .stackTop(stackTop));

  issue_unit_model issuer (.mclk(mclk), .issueReady(issueReady), .issueValid(issueValid),
    .opByte(opByte), .modrmByte(modrmByte), .waitPrefix(waitPrefix));

  task automatic chk(input string what, input logic [31:0] expv, input logic [31:0] seen);
    nCompared++;
    if (seen !== expv) begin
      badCount++;
      $display("BAD %s expected %0h seen %0h", what, expv, seen);
    end
  endtask

  task automatic end_of_test();
    $display("Compared %0d, mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wait_done(output int doneEdge);
    int n;
    for (n = 0; n < 400; n++) begin
      @(posedge mclk);
      #1;
      if (done === 1'b1) begin
        doneEdge = issuer.edges;
        return;
      end
    end
    badCount++;
    $display("BAD done expected 1 seen 0");
    end_of_test();
  endtask

  // Bit 3 of dOff set means the written register is not compared
  task automatic run_op(input logic [7:0] op, input logic [7:0] mrm, input logic wt,
      input fpu_stack_pkg::op_t eop, input int cyc, input logic [1:0] pops,
      input logic push, input logic mem, input logic [3:0] dOff);
    int tk, dn;
    logic ok;
    issuer.send(op, mrm, wt, tk, ok);
    chk("taken", 1, ok);
    chk("busy", 1, busy);
    wait_done(dn);
    chk("latency", cyc, dn - tk);
    chk("op", eop, result.op);
    chk("top", topModel, result.top);
    chk("pops", pops, result.pops);
    chk("push", push, result.push);
    chk("mem", mem, result.mem);
    if (!dOff[3]) begin
      chk("dst", 3'(topModel + dOff[2:0]), result.dst);
    end
    if (!dOff[3] && dOff[2:0] != 3'h0) begin
      chk("src", topModel, result.src);
    end
    topModel = 3'(topModel + {1'b0, pops} - {2'b00, push});
    chk("stackTop", topModel, stackTop);
  endtask

  task automatic transcendental_ops();
    run_op(8'hD9, 8'hF2, 0, fpu_stack_pkg::OP_TAN, 117, 0, 1, 0, 4'h0);
    run_op(8'hD9, 8'hFB, 0, fpu_stack_pkg::OP_SINCOS, 145, 0, 1, 0, 4'h0);
    run_op(8'hD9, 8'hF4, 0, fpu_stack_pkg::OP_XTRACT, 11, 0, 1, 0, 4'h0);
    run_op(8'hD9, 8'hF3, 0, fpu_stack_pkg::OP_ATAN, 97, 1, 0, 0, 4'h1);
    run_op(8'hD9, 8'hF1, 0, fpu_stack_pkg::OP_YL2X, 145, 1, 0, 0, 4'h1);
    run_op(8'hD9, 8'hF9, 0, fpu_stack_pkg::OP_YL2XP1, 131, 1, 0, 0, 4'h1);
    run_op(8'hD9, 8'hF8, 0, fpu_stack_pkg::OP_PREM, 82, 0, 0, 0, 4'h0);
    run_op(8'hD9, 8'hF5, 0, fpu_stack_pkg::OP_PREM1, 82, 0, 0, 0, 4'h0);
    run_op(8'hD9, 8'hFE, 0, fpu_stack_pkg::OP_SIN, 76, 0, 0, 0, 4'h0);
    run_op(8'hD9, 8'hFA, 0, fpu_stack_pkg::OP_SQRT, 59, 0, 0, 0, 4'h0);
  endtask

  task automatic store_ops();
    run_op(8'hDD, 8'hD7, 0, fpu_stack_pkg::OP_STREG, 2, 0, 0, 0, 4'h7);
    run_op(8'hDD, 8'h10, 0, fpu_stack_pkg::OP_STMEM, 2, 0, 0, 1, 4'h0);
    run_op(8'hDB, 8'hD9, 0, fpu_stack_pkg::OP_STREG, 2, 1, 0, 0, 4'h1);
    run_op(8'hDB, 8'h38, 0, fpu_stack_pkg::OP_STMEM, 2, 1, 0, 1, 4'h0);
    run_op(8'hDD, 8'h18, 0, fpu_stack_pkg::OP_STMEM, 2, 1, 0, 1, 4'h0);
    run_op(8'hD9, 8'h18, 0, fpu_stack_pkg::OP_STMEM, 2, 1, 0, 1, 4'h0);
    run_op(8'hDF, 8'h10, 0, fpu_stack_pkg::OP_ISTORE, 7, 0, 0, 1, 4'h0);
    run_op(8'hDF, 8'h30, 0, fpu_stack_pkg::OP_BCDST, 57, 1, 0, 1, 4'h0);
    run_op(8'hDB, 8'h10, 0, fpu_stack_pkg::OP_ISTORE, 8, 0, 0, 1, 4'h0);
    run_op(8'hDF, 8'h38, 0, fpu_stack_pkg::OP_ISTORE, 10, 1, 0, 1, 4'h0);
    run_op(8'hDB, 8'h18, 0, fpu_stack_pkg::OP_ISTORE, 8, 1, 0, 1, 4'h0);
    run_op(8'hD9, 8'h38, 0, fpu_stack_pkg::OP_STCW, 3, 0, 0, 1, 4'h8);
    run_op(8'hD9, 8'h30, 0, fpu_stack_pkg::OP_STENV, 12, 0, 0, 1, 4'h8);
    run_op(8'hDD, 8'h38, 0, fpu_stack_pkg::OP_STSW, 4, 0, 0, 1, 4'h8);
    run_op(8'hDF, 8'hE0, 0, fpu_stack_pkg::OP_STSWAX, 2, 0, 0, 0, 4'h8);
    run_op(8'hDD, 8'h20, 0, fpu_stack_pkg::OP_RSTOR, 56, 0, 0, 1, 4'h8);
    run_op(8'hDD, 8'h30, 0, fpu_stack_pkg::OP_SAVE, 55, 0, 0, 1, 4'h8);
  endtask

  task automatic subtract_ops();
    run_op(8'hDC, 8'hE9, 0, fpu_stack_pkg::OP_SUB, 4, 0, 0, 0, 4'h1);
    run_op(8'hD8, 8'hE2, 0, fpu_stack_pkg::OP_SUB, 4, 0, 0, 0, 4'h0);
    run_op(8'hDE, 8'hEA, 0, fpu_stack_pkg::OP_SUB, 4, 1, 0, 0, 4'h2);
    run_op(8'hD8, 8'h20, 0, fpu_stack_pkg::OP_SUB, 4, 0, 0, 1, 4'h0);
    run_op(8'hDC, 8'hE3, 0, fpu_stack_pkg::OP_SUBR, 4, 0, 0, 0, 4'h0);
    run_op(8'hD8, 8'hEC, 0, fpu_stack_pkg::OP_SUBR, 4, 0, 0, 0, 4'h4);
    run_op(8'hDE, 8'hE6, 0, fpu_stack_pkg::OP_SUBR, 4, 1, 0, 0, 4'h6);
    run_op(8'hDC, 8'h28, 0, fpu_stack_pkg::OP_SUBR, 4, 0, 0, 1, 4'h0);
    run_op(8'hDA, 8'h20, 0, fpu_stack_pkg::OP_ISUB, 14, 0, 0, 1, 4'h0);
    run_op(8'hDE, 8'h28, 0, fpu_stack_pkg::OP_ISUB, 14, 0, 0, 1, 4'h0);
  endtask

  task automatic compare_and_wait_ops();
    run_op(8'hD9, 8'hE4, 0, fpu_stack_pkg::OP_TST, 4, 0, 0, 0, 4'h8);
    run_op(8'hD9, 8'hE5, 0, fpu_stack_pkg::OP_XAM, 4, 0, 0, 0, 4'h8);
    run_op(8'hDD, 8'hEB, 0, fpu_stack_pkg::OP_UCOM, 4, 1, 0, 0, 4'h8);
    run_op(8'hDA, 8'hE9, 0, fpu_stack_pkg::OP_UCOM, 4, 2, 0, 0, 4'h8);
    run_op(8'h9B, 8'h00, 0, fpu_stack_pkg::OP_WAIT, 2, 0, 0, 0, 4'h8);
    run_op(8'hDD, 8'h38, 1, fpu_stack_pkg::OP_STSW, 6, 0, 0, 1, 4'h8);
    run_op(8'hDF, 8'hE0, 1, fpu_stack_pkg::OP_STSWAX, 4, 0, 0, 0, 4'h8);
    run_op(8'hD9, 8'h38, 1, fpu_stack_pkg::OP_STCW, 5, 0, 0, 1, 4'h8);
    run_op(8'hD9, 8'hD0, 0, fpu_stack_pkg::OP_ILLEGAL, 2, 0, 0, 0, 4'h8);
  endtask

  // Second offer arrives while busy and must wait for the edge after done
  task automatic back_to_back();
    int tk, tk2, d1, d2;
    logic ok, ok2;
    issuer.send(8'hD9, 8'hFD, 0, tk, ok);
    fork
      issuer.send(8'hD9, 8'hC9, 0, tk2, ok2);
    join_none
    wait_done(d1);
    wait_done(d2);
    chk("first latency", 7, d1 - tk);
    chk("second taken", 1, ok2);
    chk("second take", d1 + 1, tk2);
    chk("second latency", 3, d2 - tk2);
  endtask

  task automatic reset_mid_run();
    int tk;
    logic ok;
    issuer.send(8'hD9, 8'hFE, 0, tk, ok);
    repeat (10) @(negedge mclk);
    arst_n = 1'b0;
    #1;
    chk("busy in reset", 0, busy);
    chk("ready in reset", 1, issueReady);
    chk("result in reset", 0, result);
    chk("stackTop in reset", 0, stackTop);
    @(negedge mclk);
    arst_n = 1'b1;
    topModel = 3'h0;
  endtask

  initial begin
    repeat (3) @(negedge mclk);
    arst_n = 1'b1;
    chk("ready after reset", 1, issueReady);
    chk("stackTop after reset", 0, stackTop);
    transcendental_ops();
    store_ops();
    reset_mid_run();
    subtract_ops();
    compare_and_wait_ops();
    back_to_back();
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
